// ### design/gpio_port.v
// 14-pin parallel port with wishbone register slave and alternate function mux
// assumes a classic wishbone master on the same clock and pads outside
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_map.vh"
module gpio_port #(
    parameter       PINS         = 14,
    parameter [13:0] ALT_DIR_FIXED = 14'h0000,
    parameter [13:0] ALT_DIR_VALUE = 14'h0000,
    parameter [13:0] BIAS_EN_RST  = `RST_PIN_BIAS_ENABLE,
    parameter [13:0] BIAS_TY_RST  = `RST_PIN_BIAS_TYPE
) (
    input  wire          sys_clk_i,
    input  wire          nrst_i,
    // wishbone classic slave
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [17:0]   wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    output reg           wb_err_o,
    // pads
    input  wire [13:0]   pin_i,
    output wire [13:0]   pin_o,
    output wire [13:0]   pin_oe_o,
    output wire [13:0]   pull_up_en_o,
    output wire [13:0]   pull_down_en_o,
    // alternate function peripherals, code 01..11
    input  wire [13:0]   alt1_out_i,
    input  wire [13:0]   alt2_out_i,
    input  wire [13:0]   alt3_out_i,
    input  wire [13:0]   alt1_oe_i,
    input  wire [13:0]   alt2_oe_i,
    input  wire [13:0]   alt3_oe_i,
    output wire [13:0]   pin_level_o
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg  [13:0] out_value_ff;
    reg  [13:0] in_value_ff;
    reg  [13:0] direction_ff;
    reg  [13:0] alt_lo_ff;
    reg  [13:0] alt_hi_ff;
    reg  [13:0] drive_mode_ff;
    reg  [13:0] bias_type_ff;
    reg  [13:0] bias_en_ff;
    wire [13:0] pin_sync_w;

    // ----------------------------------------
    // input synchroniser and latch
    // ----------------------------------------
    pin_sync #(
        .WIDTH (PINS)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .async_i   (pin_i),
        .sync_o    (pin_sync_w)
    );

    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            in_value_ff <= 14'h0000;
        end else begin
            in_value_ff <= pin_sync_w;
        end
    end
    assign pin_level_o = in_value_ff;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // byte address = 4 * index; index bits are adr[17:2]
    wire [15:0] idx_w  = wb_adr_i[17:2];
    wire        req_w  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire        hit_out  = (idx_w == `IDX_PIN_OUTPUT_VALUE);
    wire        hit_in   = (idx_w == `IDX_PIN_INPUT_VALUE);
    wire        hit_dir  = (idx_w == `IDX_PIN_DIRECTION);
    wire        hit_alo  = (idx_w == `IDX_ALT_SELECT_LOW_BIT);
    wire        hit_ahi  = (idx_w == `IDX_ALT_SELECT_HIGH_BIT);
    wire        hit_drv  = (idx_w == `IDX_PIN_DRIVE_MODE);
    wire        hit_bty  = (idx_w == `IDX_PIN_BIAS_TYPE);
    wire        hit_ben  = (idx_w == `IDX_PIN_BIAS_ENABLE);
    wire        mapped_w = hit_out | hit_in | hit_dir | hit_alo | hit_ahi | hit_drv | hit_bty | hit_ben;
    wire        wr_w     = req_w && wb_we_i && mapped_w;

    // byte-lane merge; bits 15:14 are dropped here
    function [13:0] merge;
        input [13:0] old;
        input [31:0] wdat;
        input [3:0]  sel;
        begin
            merge[7:0]  = sel[0] ? wdat[7:0]  : old[7:0];
            merge[13:8] = sel[1] ? wdat[13:8] : old[13:8];
        end
    endfunction

    // fixed per-pin direction overrides the peripheral's own enable
    function alt_dir;
        input fixed;
        input value;
        input periph;
        begin
            alt_dir = fixed ? value : periph;
        end
    endfunction

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            out_value_ff  <= `RST_PIN_OUTPUT_VALUE;
            direction_ff  <= `RST_PIN_DIRECTION;
            alt_lo_ff     <= `RST_ALT_SELECT;
            alt_hi_ff     <= `RST_ALT_SELECT;
            drive_mode_ff <= `RST_PIN_DRIVE_MODE;
            bias_type_ff  <= BIAS_TY_RST;
            bias_en_ff    <= BIAS_EN_RST;
        end else if (wr_w) begin
            if (hit_out) out_value_ff  <= merge(out_value_ff, wb_dat_i, wb_sel_i);
            if (hit_dir) direction_ff  <= merge(direction_ff, wb_dat_i, wb_sel_i);
            if (hit_alo) alt_lo_ff     <= merge(alt_lo_ff, wb_dat_i, wb_sel_i);
            if (hit_ahi) alt_hi_ff     <= merge(alt_hi_ff, wb_dat_i, wb_sel_i);
            if (hit_drv) drive_mode_ff <= merge(drive_mode_ff, wb_dat_i, wb_sel_i);
            if (hit_bty) bias_type_ff  <= merge(bias_type_ff, wb_dat_i, wb_sel_i);
            if (hit_ben) bias_en_ff    <= merge(bias_en_ff, wb_dat_i, wb_sel_i);
        end
    end

    // ----------------------------------------
    // read mux and answer
    // ----------------------------------------
    reg [13:0] rd_w;
    always @* begin
        rd_w = 14'h0000;
        case (1'b1)
            hit_out: rd_w = out_value_ff;
            hit_in:  rd_w = in_value_ff;
            hit_dir: rd_w = direction_ff;
            hit_alo: rd_w = alt_lo_ff;
            hit_ahi: rd_w = alt_hi_ff;
            hit_drv: rd_w = drive_mode_ff;
            hit_bty: rd_w = bias_type_ff;
            hit_ben: rd_w = bias_en_ff;
            default: rd_w = 14'h0000;
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req_w && mapped_w;
            wb_err_o <= req_w && !mapped_w;
            // upper bits including reserved 15:14 read zero
            wb_dat_o <= (req_w && mapped_w && !wb_we_i) ? {18'h0_0000, rd_w} : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // pin output path
    // ----------------------------------------
    reg [13:0] lvl_w;
    reg [13:0] dir_w;
    integer    k;
    always @* begin
        lvl_w = 14'h0000;
        dir_w = 14'h0000;
        for (k = 0; k < 14; k = k + 1) begin
            case ({alt_hi_ff[k], alt_lo_ff[k]})
                2'b01: begin
                    lvl_w[k] = alt1_out_i[k];
                    dir_w[k] = alt_dir(ALT_DIR_FIXED[k], ALT_DIR_VALUE[k], alt1_oe_i[k]);
                end
                2'b10: begin
                    lvl_w[k] = alt2_out_i[k];
                    dir_w[k] = alt_dir(ALT_DIR_FIXED[k], ALT_DIR_VALUE[k], alt2_oe_i[k]);
                end
                2'b11: begin
                    lvl_w[k] = alt3_out_i[k];
                    dir_w[k] = alt_dir(ALT_DIR_FIXED[k], ALT_DIR_VALUE[k], alt3_oe_i[k]);
                end
                default: begin
                    lvl_w[k] = out_value_ff[k];
                    dir_w[k] = direction_ff[k];
                end
            endcase
        end
    end

    // open drain only ever drives low; a 1 releases the pad
    assign pin_o    = lvl_w & drive_mode_ff;
    assign pin_oe_o = dir_w & (drive_mode_ff | ~lvl_w);

    assign pull_up_en_o   = bias_en_ff & bias_type_ff;
    assign pull_down_en_o = bias_en_ff & ~bias_type_ff;
endmodule
`default_nettype wire

// ### design/gpio_port_map.vh
// register offsets, field layout, reset values for the 14-pin parallel port
// assumes 16-bit registers in the low half of a 32-bit wishbone word
// Behaviour
// - output pins drive output value register bits; register resets low
// - input value register is read-only and holds latched pin levels
// - direction from direction register in gpio mode, else peripheral or fixed
// - direction bit 0 is input, 1 is output; all pins reset to input
// - per-pin multiplexer picks the output value register bit or one of three alternate output lines
// - first alternate-select register gives the selection lsb
// - second alternate-select register gives the selection msb
// - open drain: driving 1 enables nothing, driving 0 enables pull-down only; the code drives the pad low through pin_oe_o and leaves pull_down_en_o alone
// - drive mode bit 0 is open drain, 1 push-pull; resets all ones
// - bias type bit 0 selects weak pull-down, 1 weak pull-up
// - bias enable bit 0 disables, 1 enables pull; resets all ones
// - bias type and enable are independent for every pin
// - predefined pulls are applied after reset without software
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_PIN_OUTPUT_VALUE    16'hf380
`define IDX_PIN_INPUT_VALUE     16'hf381
`define IDX_PIN_DRIVE_MODE      16'hf385
`define IDX_PIN_BIAS_ENABLE     16'hf387
`define IDX_PIN_DIRECTION       16'hf382
`define IDX_ALT_SELECT_LOW_BIT  16'hf383
`define IDX_ALT_SELECT_HIGH_BIT 16'hf384
`define IDX_PIN_BIAS_TYPE       16'hf386

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define PIN_MSB                 13
`define RST_PIN_OUTPUT_VALUE    14'h0000
`define RST_PIN_DIRECTION       14'h0000
`define RST_ALT_SELECT          14'h0000
`define RST_PIN_DRIVE_MODE      14'h3fff
`define RST_PIN_BIAS_ENABLE     14'h3fff
`define RST_PIN_BIAS_TYPE       14'h3fff

// ----------------------------------------
// alternate function selection codes
// ----------------------------------------
`define ALT_SEL_GPIO            2'b00

`endif

// ### design/pin_sync.v
// two-flop synchroniser bank for the port's input pins
// assumes pins are asynchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 14
) (
    input  wire             sys_clk_i,
    input  wire             nrst_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] stable_ff;

    // first stage is read only by the second stage
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            meta_ff   <= {WIDTH{1'b0}};
            stable_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff   <= async_i;
            stable_ff <= meta_ff;
        end
    end

    assign sync_o = stable_ff;
endmodule
`default_nettype wire

// ### verif/gpio_port_chk.sv
// concurrent checks on the parallel port slave and pad outputs
// assumes it is bound onto gpio_port, single clock domain
`timescale 1ns/1ps
`default_nettype none
module gpio_port_chk (
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic [13:0] pin_i,
    input wire logic [13:0] pull_up_en_o,
    input wire logic [13:0] pull_down_en_o,
    input wire logic [13:0] pin_level_o
);
default clocking cb @(posedge sys_clk_i); endclocking
default disable iff (!nrst_i);
sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
sequence done_s; wb_ack_o ^ wb_err_o; endsequence
a_req_answer: assert property (req_s |=> done_s) else $error("request got no single answer");
a_answer_pulse: assert property (done_s |=> !wb_ack_o && !wb_err_o) else $error("answer held over one cycle");
a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
a_rsvd_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:14] == 18'h0_0000) else $error("high bits set");
a_pull_excl: assert property ((pull_up_en_o & pull_down_en_o) == 14'h0000) else $error("both pulls on");
// three flops from pad to register, so only judged once reset is long gone
a_level_sync: assert property ($past(nrst_i, 3) && $past(nrst_i, 2) && $past(nrst_i) |-> pin_level_o == $past(pin_i, 3))
    else $error("input latch not three cycles behind pad");
endmodule
bind gpio_port gpio_port_chk gpio_port_chk_inst (.sys_clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .pin_i, .pull_up_en_o, .pull_down_en_o, .pin_level_o);
`default_nettype wire

// ### verif/pin_pads.sv
// pad wire model: resolves design drive, external driver and weak pulls
// assumes an undriven, unpulled pad floats, shown as a toggling level
`timescale 1ns/1ps
`default_nettype none
module pin_pads (
    input  wire logic        clk_i,
    input  wire logic [13:0] drv_i,
    input  wire logic [13:0] oe_i,
    input  wire logic [13:0] pu_i,
    input  wire logic [13:0] pd_i,
    input  wire logic [13:0] ext_en_i,
    input  wire logic [13:0] ext_val_i,
    output logic      [13:0] level_o
);
logic flip = 1'b0;
always @(posedge clk_i) flip <= ~flip;
always @* begin
    for (int b = 0; b < 14; b++) begin
        level_o[b] = oe_i[b] ? drv_i[b] : ext_en_i[b] ? ext_val_i[b] : pu_i[b] ? 1'b1 : pd_i[b] ? 1'b0 : flip;
    end
end
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench: random register traffic against a bench model
// assumes the pad model holds every pad by an external driver
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_map.vh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb;
logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, e;
logic [17:0] adr = 0;
logic [3:0]  sel = 0, s;
logic [31:0] wdat = 0, q, d;
logic [13:0] a1 = 0, a2 = 0, a3 = 0, o1 = 0, o2 = 0, o3 = 0, xval = 0, m[8];
wire  [31:0] rdat;
wire         ack, err;
wire  [13:0] po, poe, pu, pd, lvl, pin;
int n_mismatch = 0, n_checks = 0, seed = 32'hb43a, cyc_cnt = 0, idx;
gpio_port gpio_port_inst (.sys_clk_i(clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .pin_i(pin), .pin_o(po), .pin_oe_o(poe), .pull_up_en_o(pu), .pull_down_en_o(pd), .alt1_out_i(a1),
    .alt2_out_i(a2), .alt3_out_i(a3), .alt1_oe_i(o1), .alt2_oe_i(o2), .alt3_oe_i(o3), .pin_level_o(lvl));
pin_pads pin_pads_inst (.clk_i(clk), .drv_i(po), .oe_i(poe), .pu_i(pu), .pd_i(pd), .ext_en_i(14'h3fff),
    .ext_val_i(xval), .level_o(pin));
initial forever #2.5 clk = ~clk;
// ----------------------------------------
// bus cycles, model and closing
// ----------------------------------------
always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
        n_mismatch++;
        end_sim();
    end
end
task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task automatic wb(input logic w, input int i, input logic [31:0] dd, input logic [3:0] ss);
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; sel <= ss; wdat <= dd;
    adr <= {16'(`IDX_PIN_OUTPUT_VALUE + i), 2'b00};
    do @(posedge clk); while (!(ack === 1'b1 || err === 1'b1));
    q = rdat; e = err;
    cyc <= 0; stb <= 0;
endtask
task automatic mreset();
    m = '{14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h3fff, 14'h3fff, 14'h3fff};
endtask
task automatic check_all();
    logic [13:0] eo, eoe;
    logic [1:0]  sl;
    logic        v, r;
    repeat (5) @(posedge clk);
    for (int b = 0; b < 14; b++) begin
        sl = {m[4][b], m[3][b]};
        v = sl == 0 ? m[0][b] : sl == 1 ? a1[b] : sl == 2 ? a2[b] : a3[b];
        r = sl == 0 ? m[2][b] : sl == 1 ? o1[b] : sl == 2 ? o2[b] : o3[b];
        eo[b] = m[5][b] & v;
        eoe[b] = r & (m[5][b] | !v);
    end
    m[1] = (eoe & eo) | (~eoe & xval);
    `CHK("pin_o", eo, po)
    `CHK("pin_oe", eoe, poe)
    `CHK("pull_up", m[7] & m[6], pu)
    `CHK("pull_down", m[7] & ~m[6], pd)
    `CHK("pin_level", m[1], lvl)
    for (int i = 0; i < 8; i++) begin
        wb(0, i, 32'h0000_0000, 4'hf);
        `CHK("read", {18'h0_0000, m[i]}, q)
    end
endtask
initial begin
    mreset();
    repeat (20) @(posedge clk);
    nrst <= 1;
    check_all();
    repeat (40) begin
        repeat (3) begin
            idx = {$random(seed)} % 9;
            d = $random(seed);
            s = $random(seed);
            wb(1, idx, d, s);
            `CHK("err", idx == 8, e)
            if (idx != 8 && idx != 1 && s[0]) m[idx][7:0] = d[7:0];
            if (idx != 8 && idx != 1 && s[1]) m[idx][13:8] = d[13:8];
        end
        a1 <= $random(seed); a2 <= $random(seed); a3 <= $random(seed);
        o1 <= $random(seed); o2 <= $random(seed); o3 <= $random(seed);
        xval <= $random(seed);
        check_all();
    end
    // second reset mid-run must restore every register
    nrst <= 0;
    repeat (3) @(posedge clk);
    nrst <= 1;
    mreset();
    check_all();
    end_sim();
end
endmodule
`default_nettype wire
